/* File: rtl/address_extension_mmu.v */
/*
  Address extension unit: translates 16-bit virtual addresses into 22-bit physical addresses
  for data, fetch and DMA accesses, and holds the eight page, segment and mode registers.
  Assumes the core supplies a register-file port (page, address, read data mux, write strobe)
  and decodes the segment instructions into the strobes below.
*/
`timescale 1ns/1ps
`include "mmu_defines.vh"
module address_extension_mmu (
  input wire clk_i,
  input wire arst_n_i,
  input wire [5:0] reg_page_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  output wire reg_hit_o,
  output wire port_hit_o,
  output wire [1:0] port_index_o,
  input wire seg_load_i,
  input wire [5:0] seg_value_i,
  input wire seg_restore_i,
  input wire int_entry_i,
  input wire int_return_i,
  input wire int_active_i,
  output wire [5:0] push_segment_o,
  input wire prog_data_i,
  input wire fetch_i,
  input wire [15:0] fetch_addr_i,
  output reg [21:0] fetch_phys_o,
  input wire data_i,
  input wire dma_i,
  input wire dma_page_select_i,
  input wire [15:0] data_addr_i,
  output reg [21:0] data_phys_o,
  output wire interrupt_segment_save_o,
  output wire page_reg_relocation_o
);

////////////////////////////////////////////////////////////////////////////////

reg [7:0] data_page_ff [0:3];
reg [5:0] code_segment_ff;
reg [5:0] interrupt_segment_ff;
reg [5:0] dma_segment_ff;
reg [7:0] extended_mode_reg2_ff;
reg [5:0] nxt_code_segment;
reg [21:0] nxt_fetch_phys;
reg [21:0] nxt_data_phys;
reg [7:0] mmu_rdata;
reg [1:0] data_src;

wire on_page21;
wire reloc;
wire seg_save;
wire [1:0] dp_sel;
wire [3:0] dp_onehot;
wire dp_hit;
wire [7:0] page_rdata;
wire code_segment_hit;
wire ext_mode2_hit;
wire int_segment_hit;
wire dma_segment_hit;
wire mmu_hit;

wire [3:0] dp_write;
wire code_segment_write;
wire ext_mode2_write;
wire int_segment_write;
wire dma_segment_write;

wire entry_load;
wire jump_load;
wire stack_load;
wire int_fetch_override;
wire [5:0] fetch_seg;
wire [5:0] dma_seg;
wire [1:0] data_page_index;
wire [7:0] data_page_sel;
wire [21:0] page_phys;

////////////////////////////////////////////////////////////////////////////////
// Decoding functions.

// Returns 1 when addr falls in the four-register window starting at base.
function in_quad;
  input [7:0] addr;
  input [7:0] base;
  begin
    in_quad = (addr[7:2] == base[7:2]);
  end
endfunction

// Returns 1 when page and addr name the given register of the unit's page.
function page21_reg;
  input [5:0] page;
  input [7:0] addr;
  input [7:0] number;
  begin
    page21_reg = (page == `REG_PAGE_MMU) && (addr == number);
  end
endfunction

// Widens a six-bit segment register to a byte whose bits 7:6 read zero.
function [7:0] seg_byte;
  input [5:0] segment;
  begin
    seg_byte = {2'h0, segment};
  end
endfunction

// Places a segment over a full 16-bit virtual address.
function [21:0] segment_phys;
  input [5:0] segment;
  input [15:0] vaddr;
  begin
    segment_phys = {segment, vaddr};
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Register decode.

assign on_page21 = (reg_page_i == `REG_PAGE_MMU);
assign reloc = extended_mode_reg2_ff[`BIT_PAGE_RELOC];
assign seg_save = extended_mode_reg2_ff[`BIT_SEG_SAVE];
assign interrupt_segment_save_o = seg_save;
assign page_reg_relocation_o = reloc;

assign dp_sel = reg_addr_i[1:0];
assign dp_onehot = 4'h1 << dp_sel;
// Relocated page registers sit at R224-227, the ports take R240-243 of page 21.
assign dp_hit = reloc ? in_quad(reg_addr_i, `REG_RELOC_BASE) :
                (on_page21 && in_quad(reg_addr_i, `REG_DATA_PAGE_0));
assign port_hit_o = reloc ? (on_page21 && in_quad(reg_addr_i, `REG_PORT_BASE)) :
                    in_quad(reg_addr_i, `REG_RELOC_BASE);
assign port_index_o = reg_addr_i[1:0];

assign code_segment_hit = page21_reg(reg_page_i, reg_addr_i, `REG_CODE_SEGMENT);
assign ext_mode2_hit = page21_reg(reg_page_i, reg_addr_i, `REG_EXT_MODE2);
assign int_segment_hit = page21_reg(reg_page_i, reg_addr_i, `REG_INT_SEGMENT);
assign dma_segment_hit = page21_reg(reg_page_i, reg_addr_i, `REG_DMA_SEGMENT);
assign mmu_hit = code_segment_hit || ext_mode2_hit || int_segment_hit || dma_segment_hit;
assign reg_hit_o = dp_hit || mmu_hit;

////////////////////////////////////////////////////////////////////////////////
// Write enables.

genvar gi;
generate
  for (gi = 0; gi < 4; gi = gi + 1) begin : g_page_write
    assign dp_write[gi] = reg_wr_i && dp_hit && dp_onehot[gi];
  end
endgenerate

assign code_segment_write = reg_wr_i && code_segment_hit;
assign ext_mode2_write = reg_wr_i && ext_mode2_hit;
assign int_segment_write = reg_wr_i && int_segment_hit;
assign dma_segment_write = reg_wr_i && dma_segment_hit;

////////////////////////////////////////////////////////////////////////////////
// Register reads.

assign page_rdata = data_page_ff[dp_sel];

always @* begin
  mmu_rdata = 8'h00;
  case (reg_addr_i)
    `REG_CODE_SEGMENT: begin
      mmu_rdata = seg_byte(code_segment_ff);
    end
    `REG_EXT_MODE2: begin
      mmu_rdata = extended_mode_reg2_ff;
    end
    `REG_INT_SEGMENT: begin
      mmu_rdata = seg_byte(interrupt_segment_ff);
    end
    `REG_DMA_SEGMENT: begin
      mmu_rdata = seg_byte(dma_segment_ff);
    end
    default: begin
      mmu_rdata = 8'h00;
    end
  endcase
end

always @* begin
  reg_rdata_o = 8'h00;
  if (dp_hit) begin
    reg_rdata_o = page_rdata;
  end else if (on_page21) begin
    reg_rdata_o = mmu_rdata;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Registers without reset value.

generate
  for (gi = 0; gi < 4; gi = gi + 1) begin : g_page
    always @(posedge clk_i) begin
      if (dp_write[gi]) begin
        data_page_ff[gi] <= reg_wdata_i;
      end
    end
  end
endgenerate

always @(posedge clk_i) begin
  if (int_segment_write) begin
    interrupt_segment_ff <= reg_wdata_i[5:0];
  end
end

always @(posedge clk_i) begin
  if (dma_segment_write) begin
    dma_segment_ff <= reg_wdata_i[5:0];
  end
end

////////////////////////////////////////////////////////////////////////////////
// Code segment and extended mode register.

assign entry_load = int_entry_i && seg_save;
assign jump_load = seg_load_i;
assign stack_load = seg_restore_i || (int_return_i && seg_save);
assign push_segment_o = code_segment_ff;

// Hardware loads outrank a register write that lands in the same cycle.
always @* begin
  nxt_code_segment = code_segment_ff;
  if (entry_load) begin
    nxt_code_segment = interrupt_segment_ff;
  end else if (jump_load) begin
    nxt_code_segment = seg_value_i;
  end else if (stack_load) begin
    nxt_code_segment = seg_value_i;
  end else if (code_segment_write) begin
    nxt_code_segment = reg_wdata_i[5:0];
  end
end

always @(posedge clk_i or negedge arst_n_i) begin
  if (!arst_n_i) begin
    code_segment_ff <= `CODE_SEGMENT_RESET;
  end else begin
    code_segment_ff <= nxt_code_segment;
  end
end

always @(posedge clk_i or negedge arst_n_i) begin
  if (!arst_n_i) begin
    extended_mode_reg2_ff <= `EXT_MODE2_RESET;
  end else if (ext_mode2_write) begin
    extended_mode_reg2_ff <= reg_wdata_i;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Translation.

localparam SRC_PAGE = 2'h0;
localparam SRC_PROG = 2'h1;
localparam SRC_DMA = 2'h2;

// In service with save clear the interrupt segment stands in for the code segment.
assign int_fetch_override = int_active_i && !seg_save;
assign fetch_seg = int_fetch_override ? interrupt_segment_ff : code_segment_ff;
assign dma_seg = dma_page_select_i ? dma_segment_ff : interrupt_segment_ff;
assign data_page_index = data_addr_i[15:14];
assign data_page_sel = data_page_ff[data_page_index];
// Eight page bits over fourteen offset bits give the 22-bit physical address.
assign page_phys = {data_page_sel, data_addr_i[13:0]};

always @* begin
  nxt_fetch_phys = fetch_phys_o;
  if (fetch_i) begin
    nxt_fetch_phys = segment_phys(fetch_seg, fetch_addr_i);
  end
end

always @* begin
  data_src = SRC_PAGE;
  if (dma_i) begin
    data_src = SRC_DMA;
  end else if (prog_data_i) begin
    data_src = SRC_PROG;
  end
end

always @* begin
  nxt_data_phys = data_phys_o;
  if (data_i) begin
    case (data_src)
      SRC_DMA: begin
        nxt_data_phys = segment_phys(dma_seg, data_addr_i);
      end
      SRC_PROG: begin
        nxt_data_phys = segment_phys(fetch_seg, data_addr_i);
      end
      default: begin
        nxt_data_phys = page_phys;
      end
    endcase
  end
end

// Six segment bits over sixteen offset bits fill the same 22 bits.
always @(posedge clk_i or negedge arst_n_i) begin
  if (!arst_n_i) begin
    fetch_phys_o <= `PHYS_RESET;
  end else begin
    fetch_phys_o <= nxt_fetch_phys;
  end
end

always @(posedge clk_i or negedge arst_n_i) begin
  if (!arst_n_i) begin
    data_phys_o <= `PHYS_RESET;
  end else begin
    data_phys_o <= nxt_data_phys;
  end
end

endmodule // address_extension_mmu

/* File: rtl/mmu_defines.vh */
/*
  Constants of the address extension unit: register numbers, field positions, reset values.
  Assumes inclusion by the unit's single design file.
*/
`ifndef MMU_DEFINES_VH
`define MMU_DEFINES_VH
`define REG_PAGE_MMU 6'h15
`define REG_DATA_PAGE_0 8'hF0
`define REG_DATA_PAGE_1 8'hF1
`define REG_DATA_PAGE_2 8'hF2
`define REG_DATA_PAGE_3 8'hF3
`define REG_CODE_SEGMENT 8'hF4
`define REG_EXT_MODE2 8'hF6
`define REG_INT_SEGMENT 8'hF8
`define REG_DMA_SEGMENT 8'hF9
`define REG_RELOC_BASE 8'hE0
`define REG_PORT_BASE 8'hF0
`define BIT_SEG_SAVE 6
`define BIT_PAGE_RELOC 5
`define CODE_SEGMENT_RESET 6'h00
`define EXT_MODE2_RESET 8'h00
`define PHYS_RESET 22'h000000
`endif

/* File: verif/address_extension_mmu_properties.sv */
/* Port checker of the address extension unit.
   Assumes a bind to address_extension_mmu. */
`timescale 1ns/1ps
module address_extension_mmu_properties (
  input wire clk_i, arst_n_i, reg_wr_i, data_i, dma_i, prog_data_i, fetch_i, int_active_i,
  input wire seg_load_i, int_entry_i, interrupt_segment_save_o, page_reg_relocation_o,
  input wire [5:0] reg_page_i, seg_value_i, push_segment_o,
  input wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
  input wire [15:0] data_addr_i, fetch_addr_i,
  input wire [21:0] data_phys_o, fetch_phys_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  a_page_offset: assert property (data_i && !dma_i && !prog_data_i
    |=> data_phys_o[13:0] == $past(data_addr_i[13:0])) else $error("page offset wrong");
  a_dma_offset: assert property (data_i && dma_i |=> data_phys_o[15:0] == $past(data_addr_i))
    else $error("dma offset wrong");
  a_fetch_offset: assert property (fetch_i |=> fetch_phys_o[15:0] == $past(fetch_addr_i))
    else $error("fetch offset wrong");
  a_fetch_code: assert property (fetch_i && !int_active_i ##1 $stable(push_segment_o)
    |-> fetch_phys_o[21:16] == push_segment_o) else $error("fetch segment wrong");
  a_seg_load: assert property (seg_load_i && !(int_entry_i && interrupt_segment_save_o)
    |=> push_segment_o == $past(seg_value_i)) else $error("segment load lost");
  a_code_reserved: assert property (reg_page_i == 6'h15 && reg_addr_i == 8'hF4
    |-> reg_rdata_o[7:6] == 2'b00) else $error("code segment top bits set");
  a_code_reset: assert property ($rose(arst_n_i) |-> push_segment_o == 6'h00)
    else $error("code segment not cleared");
  a_mode_bits: assert property (reg_wr_i && reg_page_i == 6'h15 && reg_addr_i == 8'hF6
    |=> {interrupt_segment_save_o, page_reg_relocation_o} == $past(reg_wdata_i[6:5])) else $error("mode bits wrong");
endmodule // address_extension_mmu_properties
bind address_extension_mmu address_extension_mmu_properties i_address_extension_mmu_properties (.*);

/* File: verif/address_extension_mmu_test.sv */
/* Testbench of the address extension unit: register access and translation checks.
   Assumes the unit, its checker and the cpu model are compiled first. */
`timescale 1ns/1ps
module address_extension_mmu_test;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic reg_wr_i, seg_load_i, seg_restore_i, int_entry_i, int_return_i, int_active_i, prog_data_i, fetch_i, data_i;
  logic dma_i, dma_page_select_i, reg_hit_o, port_hit_o, interrupt_segment_save_o, page_reg_relocation_o;
  logic [1:0] port_index_o;
  logic [5:0] reg_page_i, seg_value_i, push_segment_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [15:0] fetch_addr_i, data_addr_i;
  logic [21:0] fetch_phys_o, data_phys_o;
  int err_count = 0;
  int comparisons = 0;
  address_extension_mmu i_address_extension_mmu (.*);
  cpu i_cpu (.*);
  always #20 clk_i = ~clk_i;
  task automatic chk(input string n, input logic [21:0] got, input logic [21:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    arst_n_i = 1'h1;
    i_cpu.sel(8'hF4, 6'h15);
    chk("code", reg_rdata_o, 8'h00);
    chk("code hit", reg_hit_o, 1'h1);
    i_cpu.sel(8'hE2, 6'h00);
    chk("home port", {reg_hit_o, port_hit_o, port_index_o}, 4'h6);
    for (int k = 0; k < 4; k++) i_cpu.wr(8'hF0 + k[7:0], 8'hA0 + k[7:0]);
    for (int k = 0; k < 4; k++) begin
      i_cpu.sel(8'hF0 + k[7:0], 6'h15);
      chk("page", reg_rdata_o, 8'hA0 + k[7:0]);
      i_cpu.acc(1'h0, {k[1:0], 14'h3FFF}, 3'h0);
      chk("data", data_phys_o, {8'hA0 + k[7:0], 14'h3FFF});
    end
    i_cpu.pulse(5'h10, 6'h00);
    i_cpu.wr(8'hF4, 8'hFF);
    i_cpu.wr(8'hF8, 8'h11);
    i_cpu.wr(8'hF9, 8'h22);
    i_cpu.sel(8'hF4, 6'h15);
    chk("code", reg_rdata_o, 8'h3F);
    i_cpu.sel(8'hF9, 6'h15);
    chk("dma seg", reg_rdata_o, 8'h22);
    i_cpu.acc(1'h1, 16'h1234, 3'h0);
    chk("int fetch", fetch_phys_o, {6'h11, 16'h1234});
    for (int k = 0; k < 2; k++) begin
      i_cpu.acc(1'h0, 16'hBEEF, {1'h1, k[0], 1'h0});
      chk("dma", data_phys_o, {k[0] ? 6'h22 : 6'h11, 16'hBEEF});
    end
    i_cpu.pulse(5'h00, 6'h00);
    i_cpu.acc(1'h1, 16'hCAFE, 3'h0);
    chk("fetch", fetch_phys_o, {6'h3F, 16'hCAFE});
    i_cpu.acc(1'h0, 16'h0042, 3'h1);
    chk("prog data", data_phys_o, {6'h3F, 16'h0042});
    i_cpu.pulse(5'h08, 6'h2A);
    chk("load", push_segment_o, 6'h2A);
    i_cpu.pulse(5'h04, 6'h15);
    chk("restore", push_segment_o, 6'h15);
    i_cpu.wr(8'hF6, 8'h40);
    chk("save", interrupt_segment_save_o, 1'h1);
    i_cpu.pulse(5'h12, 6'h00);
    chk("entry", push_segment_o, 6'h11);
    i_cpu.pulse(5'h01, 6'h15);
    chk("iret", push_segment_o, 6'h15);
    i_cpu.wr(8'hF6, 8'h20);
    chk("reloc", page_reg_relocation_o, 1'h1);
    i_cpu.sel(8'hE0, 6'h00);
    chk("moved page", reg_rdata_o, 8'hA0);
    chk("moved hit", {reg_hit_o, port_hit_o}, 2'h2);
    i_cpu.sel(8'hF0, 6'h15);
    chk("port", {port_hit_o, port_index_o}, 3'h4);
    chk("port not reg", reg_hit_o, 1'h0);
    i_cpu.sel(8'hFF, 6'h15);
    chk("unmapped", reg_rdata_o, 8'h00);
    chk("unmapped hit", reg_hit_o, 1'h0);
    summarize;
  end
endmodule // address_extension_mmu_test

/* File: verif/cpu.sv */
/* Core-side model: register-file port, segment strobes and address paths.
   Assumes the unit's clock; requests change at falling edges. */
`timescale 1ns/1ps
module cpu (
  input wire clk_i,
  output logic reg_wr_i, seg_load_i, seg_restore_i, int_entry_i, int_return_i, int_active_i,
  output logic prog_data_i, fetch_i, data_i, dma_i, dma_page_select_i,
  output logic [5:0] reg_page_i, seg_value_i,
  output logic [7:0] reg_addr_i, reg_wdata_i,
  output logic [15:0] fetch_addr_i, data_addr_i
);
  initial begin
    {reg_wr_i, seg_load_i, seg_restore_i, int_entry_i, int_return_i, int_active_i, prog_data_i, fetch_i} = '0;
    {data_i, dma_i, dma_page_select_i, reg_page_i, seg_value_i, reg_addr_i, reg_wdata_i, fetch_addr_i, data_addr_i} = '0;
  end
  // Page registers change through the register file only.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_page_i = 6'h15;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'h1;
    @(negedge clk_i);
    reg_wr_i = 1'h0;
    reg_wdata_i = ~d;
  endtask
  task automatic sel(input logic [7:0] a, input logic [5:0] p);
    @(negedge clk_i);
    reg_page_i = p;
    reg_addr_i = a;
    #1;
  endtask
  task automatic acc(input logic f, input logic [15:0] a, input logic [2:0] m);
    @(negedge clk_i);
    {fetch_i, data_i} = {f, !f};
    {dma_i, dma_page_select_i, prog_data_i} = m;
    fetch_addr_i = a;
    data_addr_i = a;
    @(negedge clk_i);
    {fetch_i, data_i} = 2'h0;
    fetch_addr_i = ~a;
    data_addr_i = ~a;
  endtask
  task automatic pulse(input logic [4:0] s, input logic [5:0] v);
    @(negedge clk_i);
    {int_active_i, seg_load_i, seg_restore_i, int_entry_i, int_return_i} = s;
    seg_value_i = v;
    @(negedge clk_i);
    {seg_load_i, seg_restore_i, int_entry_i, int_return_i} = 4'h0;
    seg_value_i = ~v;
  endtask
endmodule // cpu
